// ---- hdl/rotate_subtract_swap_datapath.sv ----
// top of the 8-bit datapath slice: accumulator, file bank, status, watchdog
// assumes a classic wishbone master on core_clk; rstn asynchronous active low
//
// Operation
// [RQ1] rotate right through carry: bit 0 to carry, old carry to bit 7
// [RQ2] destination bit 0 writes the accumulator, 1 writes the file register
// [RQ3] sleep clears the watchdog counter and its prescaler
// [RQ4] sleep sets timeout status to 1 and clears powerdown status to 0
// [RQ5] literal minus accumulator, result always into the accumulator, flags updated
// [RQ6] literal subtract: carry and digit carry clear only when accumulator is larger
// [RQ7] file minus accumulator, result to selected destination, flags updated
// [RQ8] file subtract: carry and digit carry clear only when accumulator is larger
// [RQ9] file minus accumulator minus inverted carry, routed by destination bit
// [RQ10] nibble exchange swaps halves and leaves all flags unchanged
// [RQ11] rotate left through carry: bit 7 to carry, old carry to bit 0
// [RQ12] zero flag set exactly when the 8-bit result is zero
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
module rotate_subtract_swap_datapath #(
    parameter int unsigned WDOG_W = dp_pkg::WDOG_W_DEF, // watchdog counter width
    parameter int unsigned PRESC_W = dp_pkg::PRESC_W_DEF // watchdog prescaler width
) (
    input wire logic core_clk, // core clock, 25 MHz
    input wire logic rstn, // asynchronous reset, active low
    input wire logic wbCycI, // wishbone cycle
    input wire logic wbStbI, // wishbone strobe
    input wire logic wbWeI, // wishbone write enable
    input wire logic [7:0] wbAdrI, // wishbone byte address
    input wire logic [3:0] wbSelI, // wishbone byte lane selects
    input wire logic [31:0] wbDatI, // wishbone write data
    output logic [31:0] wbDatO, // wishbone read data
    output logic wbAckO, // wishbone acknowledge
    output logic timeoutStatus, // timeout status flag
    output logic powerdownStatus // powerdown status flag
);
    import dp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] accQ; // accumulator
    logic [7:0] fileMem [FILE_DEPTH]; // file register bank
    logic [ST_W-1:0] statusQ; // flags: c, dc, z, powerdown, timeout
    logic [15:0] cmdQ; // last command written
    logic [7:0] resultQ; // last result produced
    logic [WDOG_W-1:0] wdogQ; // watchdog counter
    logic [PRESC_W-1:0] prescQ; // watchdog prescaler

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic busReq; // request present
    logic reqNew; // request seen, not yet answered
    logic wrTake; // write commits at this edge
    logic [7:0] wordAdr; // word-aligned byte address
    logic isFile; // address falls in the file bank
    logic [FILE_ADDR_W-1:0] fileIdx; // bank index of a bus access

    // request qualification
    assign busReq = wbCycI & wbStbI;
    assign reqNew = busReq & ~wbAckO;
    assign wrTake = busReq & wbAckO & wbWeI;
    assign wordAdr = {wbAdrI[7:2], 2'b00};
    // upper bound in nine bits; the end of the bank, 8'h80, also fits in eight
    assign isFile = (wordAdr >= OFS_FILE_BASE) &&
                    ({1'b0, wordAdr} < {1'b0, OFS_FILE_BASE} + 9'(FILE_DEPTH * 4));
    assign fileIdx = wbAdrI[2 +: FILE_ADDR_W];

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    logic execGo; // command executes at this edge
    op_t cmdOp; // operation field
    logic cmdDest; // destination bit
    logic [FILE_ADDR_W-1:0] cmdAddr; // file register address
    logic [7:0] cmdLit; // literal operand
    logic writeAcc; // result goes to the accumulator
    logic writeFile; // result goes to the file register
    logic sleepGo; // sleep executes at this edge

    // a command needs both low lanes to carry its fields
    assign execGo = wrTake && (wordAdr == OFS_CMD) && (wbSelI[1:0] == 2'b11);
    assign cmdOp = op_t'(wbDatI[CMD_OP_LSB +: 3]);
    assign cmdDest = wbDatI[CMD_DEST_BIT];
    assign cmdAddr = wbDatI[CMD_ADDR_LSB +: FILE_ADDR_W];
    assign cmdLit = wbDatI[CMD_LIT_LSB +: 8];
    assign sleepGo = execGo && (cmdOp == OP_SLEEP);

    ////////////////////////////////////////////////////////////////////////////
    // alu

    alu_if alu ();

    // operand selection
    assign alu.op = execGo ? cmdOp : OP_NONE;
    assign alu.src = (cmdOp == OP_LITERAL_MINUS_ACC) ? cmdLit : fileMem[cmdAddr];
    assign alu.acc = accQ;
    assign alu.carryIn = statusQ[ST_C];

    alu_core aluCore (
        .alu(alu.core)
    );

    // result routing by destination bit
    assign writeAcc = execGo && alu.hasResult &&
                      (alu.toAcc || (cmdDest == CMD_DEST_ACC)); // RQ2 RQ5
    assign writeFile = execGo && alu.hasResult &&
                       !alu.toAcc && (cmdDest != CMD_DEST_ACC); // RQ2 RQ7 RQ9

    ////////////////////////////////////////////////////////////////////////////
    // accumulator

    // bus write or command result
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            accQ <= ACC_RST;
        end else if (writeAcc) begin
            accQ <= alu.result; // RQ2
        end else if (wrTake && (wordAdr == OFS_ACC) && wbSelI[0]) begin
            accQ <= wbDatI[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // file register bank

    // bus write or command result
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < FILE_DEPTH; i++) begin
                fileMem[i] <= FILE_RST;
            end
        end else if (writeFile) begin
            fileMem[cmdAddr] <= alu.result; // RQ2
        end else if (wrTake && isFile && wbSelI[0]) begin
            fileMem[fileIdx] <= wbDatI[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags

    // command flag updates, sleep, or a software write
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            statusQ <= STATUS_RST;
        end else if (sleepGo) begin
            statusQ[ST_TO] <= 1'b1; // RQ4
            statusQ[ST_PWRDN] <= 1'b0; // RQ4
        end else if (execGo) begin
            // nibble exchange asserts no update, flags hold
            if (alu.updC) begin
                statusQ[ST_C] <= alu.carryOut; // RQ1 RQ11 RQ6 RQ8
            end
            if (alu.updDcZ) begin
                statusQ[ST_DC] <= alu.dcOut; // RQ6 RQ8
                statusQ[ST_Z] <= alu.zeroOut; // RQ12
            end
        end else if (wrTake && (wordAdr == OFS_STATUS) && wbSelI[0]) begin
            statusQ <= wbDatI[ST_W-1:0];
        end
    end

    // flag pins follow the status register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            timeoutStatus <= STATUS_RST[ST_TO];
            powerdownStatus <= STATUS_RST[ST_PWRDN];
        end else begin
            timeoutStatus <= statusQ[ST_TO];
            powerdownStatus <= statusQ[ST_PWRDN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command and result record

    // keeps the last command and result for readback
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmdQ <= CMD_RST;
            resultQ <= ACC_RST;
        end else if (execGo) begin
            cmdQ <= wbDatI[15:0];
            if (alu.hasResult) begin
                resultQ <= alu.result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog

    // free-running prescaler feeds the counter; sleep clears both
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prescQ <= '0;
            wdogQ <= '0;
        end else if (sleepGo) begin
            prescQ <= '0; // RQ3
            wdogQ <= '0; // RQ3
        end else begin
            prescQ <= prescQ + 1'b1;
            if (&prescQ) begin
                wdogQ <= wdogQ + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus answer

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wbAckO <= 1'b0;
        end else begin
            wbAckO <= reqNew;
        end
    end

    // read data captured with the ack; unmapped words read zero
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wbDatO <= 32'h0000_0000;
        end else if (reqNew && !wbWeI) begin
            if (isFile) begin
                wbDatO <= {24'h00_0000, fileMem[fileIdx]};
            end else begin
                unique case (wordAdr)
                    OFS_ACC: wbDatO <= {24'h00_0000, accQ};
                    OFS_STATUS: wbDatO <= {27'h000_0000, statusQ};
                    OFS_CMD: wbDatO <= {16'h0000, cmdQ};
                    OFS_WDOG: wbDatO <= 32'(wdogQ);
                    OFS_RESULT: wbDatO <= {24'h00_0000, resultQ};
                    default: wbDatO <= 32'h0000_0000;
                endcase
            end
        end else begin
            wbDatO <= 32'h0000_0000;
        end
    end

endmodule : rotate_subtract_swap_datapath

// ---- hdl/dp_pkg.sv ----
// constants and types shared by the 8-bit datapath slice and its alu core
// assumes a 32-bit classic wishbone bus with byte addresses, one word per register
package dp_pkg;

    // data width of the accumulator, file registers and results
    localparam int unsigned DATA_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_ACC = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_WDOG = 8'h0c;
    localparam logic [7:0] OFS_RESULT = 8'h10;
    localparam logic [7:0] OFS_FILE_BASE = 8'h40;

    // file register bank
    localparam int unsigned FILE_ADDR_W = 4;
    localparam int unsigned FILE_DEPTH = 16;

    // status field positions
    localparam int unsigned ST_C = 0;
    localparam int unsigned ST_DC = 1;
    localparam int unsigned ST_Z = 2;
    localparam int unsigned ST_PWRDN = 3;
    localparam int unsigned ST_TO = 4;
    localparam int unsigned ST_W = 5;
    // timeout and powerdown read 1 after reset, arithmetic flags 0
    localparam logic [4:0] STATUS_RST = 5'h18;

    // command field positions
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_DEST_BIT = 3;
    localparam int unsigned CMD_ADDR_LSB = 4;
    localparam int unsigned CMD_LIT_LSB = 8;
    localparam logic CMD_DEST_ACC = 1'b0;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] FILE_RST = 8'h00;
    localparam logic [15:0] CMD_RST = 16'h0008;

    // watchdog defaults
    localparam int unsigned WDOG_W_DEF = 16;
    localparam int unsigned PRESC_W_DEF = 7;

    // operation codes
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_ROTATE_RIGHT_CARRY = 3'h1,
        OP_ROTATE_LEFT_CARRY = 3'h2,
        OP_LITERAL_MINUS_ACC = 3'h3,
        OP_FILE_MINUS_ACC = 3'h4,
        OP_FILE_MINUS_ACC_BORROW = 3'h5,
        OP_NIBBLE_EXCHANGE = 3'h6,
        OP_SLEEP = 3'h7
    } op_t;

endpackage : dp_pkg

// ---- hdl/alu_if.sv ----
// operand and result bundle between the datapath top and its alu core
// assumes dp_pkg is compiled first
`timescale 1ns/100ps
interface alu_if;
    import dp_pkg::*;
    op_t op; // operation to evaluate
    logic [7:0] src; // file value or literal
    logic [7:0] acc; // accumulator value
    logic carryIn; // current carry flag
    logic [7:0] result; // computed result
    logic carryOut; // new carry
    logic dcOut; // new digit carry
    logic zeroOut; // new zero flag
    logic updC; // carry is affected
    logic updDcZ; // digit carry and zero are affected
    logic hasResult; // operation produces a result
    logic toAcc; // result always goes to the accumulator

    modport core (
        input op, src, acc, carryIn,
        output result, carryOut, dcOut, zeroOut, updC, updDcZ, hasResult, toAcc
    );
    modport user (
        output op, src, acc, carryIn,
        input result, carryOut, dcOut, zeroOut, updC, updDcZ, hasResult, toAcc
    );
endinterface : alu_if

// ---- hdl/alu_core.sv ----
// combinational alu: rotates, subtracts and nibble exchange
// assumes operands are stable for the whole cycle in which the top commits them
`timescale 1ns/100ps
module alu_core (
    alu_if.core alu // operands in, result and flags out
);
    import dp_pkg::*;

    // subtract is a + ~w + carry-in; carry-in 1 for plain subtract
    function automatic logic [8:0] subAdd(input logic [7:0] a, input logic [7:0] w,
                                          input logic cin);
        subAdd = {1'b0, a} + {1'b0, ~w} + {8'h00, cin};
    endfunction : subAdd

    // low-nibble carry of the same sum gives the digit carry
    function automatic logic nibCarry(input logic [7:0] a, input logic [7:0] w,
                                      input logic cin);
        logic [4:0] s;
        s = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + {4'h0, cin};
        nibCarry = s[4];
    endfunction : nibCarry

    // operation decode
    always_comb begin
        logic [8:0] sum;
        logic cin;
        sum = 9'h000;
        cin = 1'b1;
        alu.result = alu.src;
        alu.carryOut = alu.carryIn;
        alu.dcOut = 1'b0;
        alu.updC = 1'b0;
        alu.updDcZ = 1'b0;
        alu.hasResult = 1'b0;
        alu.toAcc = 1'b0;
        unique case (alu.op)
            OP_ROTATE_RIGHT_CARRY: begin
                alu.result = {alu.carryIn, alu.src[7:1]}; // RQ1
                alu.carryOut = alu.src[0]; // RQ1
                alu.updC = 1'b1;
                alu.hasResult = 1'b1;
            end
            OP_ROTATE_LEFT_CARRY: begin
                alu.result = {alu.src[6:0], alu.carryIn}; // RQ11
                alu.carryOut = alu.src[7]; // RQ11
                alu.updC = 1'b1;
                alu.hasResult = 1'b1;
            end
            OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC, OP_FILE_MINUS_ACC_BORROW: begin
                // borrow form adds carry, i.e. subtracts its complement
                cin = (alu.op == OP_FILE_MINUS_ACC_BORROW) ? alu.carryIn : 1'b1; // RQ9
                sum = subAdd(alu.src, alu.acc, cin); // RQ5 RQ7 RQ9
                alu.result = sum[7:0];
                alu.carryOut = sum[8]; // RQ6 RQ8
                alu.dcOut = nibCarry(alu.src, alu.acc, cin); // RQ6 RQ8
                alu.updC = 1'b1;
                alu.updDcZ = 1'b1;
                alu.hasResult = 1'b1;
                alu.toAcc = (alu.op == OP_LITERAL_MINUS_ACC); // RQ5
            end
            OP_NIBBLE_EXCHANGE: begin
                alu.result = {alu.src[3:0], alu.src[7:4]}; // RQ10
                alu.hasResult = 1'b1;
            end
            OP_NONE, OP_SLEEP: begin
                alu.result = alu.src;
            end
        endcase
    end

    // zero flag from the 8-bit result
    assign alu.zeroOut = (alu.result == 8'h00); // RQ12

endmodule : alu_core

// ---- testbench/rotate_subtract_swap_datapath_chk.sv ----
// checker for the datapath slice: bus handshake, read data and status pins
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/100ps
module rotate_subtract_swap_datapath_chk
    import dp_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic rstn, // async reset, active low
    input wire logic wbCycI, // bus cycle
    input wire logic wbStbI, // bus strobe
    input wire logic wbWeI, // bus write enable
    input wire logic [7:0] wbAdrI, // bus address
    input wire logic [3:0] wbSelI, // byte lanes
    input wire logic [31:0] wbDatI, // write data
    input wire logic [31:0] wbDatO, // read data
    input wire logic wbAckO, // acknowledge
    input wire logic timeoutStatus, // timeout pin
    input wire logic powerdownStatus // powerdown pin
);
    logic req;
    logic sleepWr;
    logic unmapRd;
    logic [2:0] sinceWr_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    // decoded bus events
    assign req = wbCycI && wbStbI && !wbAckO;
    assign sleepWr = wbCycI && wbStbI && wbWeI && wbAckO && wbAdrI[7:2] == OFS_CMD[7:2]
        && wbSelI[1:0] == 2'h3 && wbDatI[2:0] == OP_SLEEP;
    assign unmapRd = wbAckO && !wbWeI && (wbAdrI[7] || (wbAdrI >= 8'h14 && wbAdrI < 8'h40));

    // cycles since the last acknowledged write, saturating
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sinceWr_q <= 3'h7;
        end else if (wbAckO && wbWeI) begin
            sinceWr_q <= 3'h0;
        end else if (sinceWr_q != 3'h7) begin
            sinceWr_q <= sinceWr_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    AST_ACK_LATENCY: assert property (req |=> wbAckO)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (wbAckO |=> !wbAckO)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wbAckO |-> $past(wbCycI && wbStbI))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wbAckO |-> wbDatO == 32'h0)
        else $error("read data not zero outside ack");
    AST_DAT_UPPER: assert property (wbAckO |-> wbDatO[31:16] == 16'h0)
        else $error("upper read data not zero");
    AST_UNMAPPED_READ: assert property (unmapRd |-> wbDatO == 32'h0)
        else $error("unmapped read not zero");
    AST_SLEEP_STATUS: assert property (sleepWr |-> ##[1:3] (timeoutStatus && !powerdownStatus))
        else $error("sleep did not set timeout and clear powerdown");
    AST_STATUS_CAUSE: assert property ($changed(timeoutStatus) || $changed(powerdownStatus)
        |-> sinceWr_q < 3'h4)
        else $error("status pin changed without a write");

    // main scenarios reached
    cover property (sleepWr);
    cover property (unmapRd);
    cover property ($fell(powerdownStatus));
endmodule : rotate_subtract_swap_datapath_chk

bind rotate_subtract_swap_datapath rotate_subtract_swap_datapath_chk chk (
    .core_clk(core_clk), .rstn(rstn), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI),
    .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO),
    .timeoutStatus(timeoutStatus), .powerdownStatus(powerdownStatus));

// ---- testbench/rotate_subtract_swap_datapath_bench.sv ----
// self-checking bench for the datapath slice with a reference model
// assumes dp_pkg, alu_if, alu_core and the top are compiled first
`timescale 1ns/100ps
module rotate_subtract_swap_datapath_bench;
    import dp_pkg::*;
    typedef struct {string what; logic [31:0] val;} note_t;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic wbCycI = 1'b0, wbStbI = 1'b0, wbWeI = 1'b0;
    logic [7:0] wbAdrI = 8'h00;
    logic [3:0] wbSelI = 4'h0;
    logic [31:0] wbDatI = 32'h0, wbDatO;
    logic wbAckO, timeoutStatus, powerdownStatus;
    int n_fail = 0, comparisons = 0;
    note_t expQ[$], nt;
    logic [31:0] lfsr = 32'hdacf;
    logic [7:0] acc = 8'h00, fileM[16], res, src;
    logic c = 1'b0, dc = 1'b0, z = 1'b0, to = 1'b1, pwrdn = 1'b1;

    rotate_subtract_swap_datapath #(.WDOG_W(16), .PRESC_W(3)) uut (
        .core_clk(core_clk), .rstn(rstn), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI),
        .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI), .wbDatO(wbDatO),
        .wbAckO(wbAckO), .timeoutStatus(timeoutStatus), .powerdownStatus(powerdownStatus));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        repeat (30000) @(posedge core_clk);
        n_fail++;
        results();
    end

    function automatic logic [31:0] nextRand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : nextRand

    task automatic cmpVal(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmpVal

    // one classic cycle, held until ack is sampled
    task automatic wbXfer(logic we, logic [7:0] adr, logic [3:0] sel, logic [31:0] dat);
        @(posedge core_clk);
        wbCycI <= 1'b1; wbStbI <= 1'b1; wbWeI <= we;
        wbAdrI <= adr; wbSelI <= sel; wbDatI <= dat;
        do @(posedge core_clk); while (wbAckO !== 1'b1);
        wbCycI <= 1'b0;
        wbStbI <= 1'b0;
    endtask : wbXfer

    task automatic wbRead(logic [7:0] adr, logic [31:0] exp, string what);
        expQ.push_back('{what, exp});
        wbXfer(1'b0, adr, 4'hf, 32'h0);
    endtask : wbRead

    // read data is compared against the oldest note at each read ack
    always @(posedge core_clk) begin
        if (wbAckO === 1'b1 && wbWeI === 1'b0) begin
            if (expQ.size() == 0) begin
                cmpVal("unexpected read", 32'h0, 32'hffffffff);
            end else begin
                nt = expQ.pop_front();
                cmpVal(nt.what, nt.val, wbDatO);
            end
        end
    end

    // reference model of one operation, then register checks
    task automatic runOp(logic [2:0] op, logic d, logic [3:0] idx, logic [7:0] lit);
        logic [8:0] s9;
        logic [4:0] s5;
        logic cin;
        src = (op == OP_LITERAL_MINUS_ACC) ? lit : fileM[idx];
        cin = (op == OP_FILE_MINUS_ACC_BORROW) ? c : 1'b1;
        // plain difference minus borrow; a borrow out means carry clear
        s9 = {1'b0, src} - {1'b0, acc} - {8'h0, ~cin};
        s5 = {1'b0, src[3:0]} - {1'b0, acc[3:0]} - {4'h0, ~cin};
        wbXfer(1'b1, OFS_CMD, 4'hf, {16'h0, lit, idx, d, op});
        if (op == 3'h1) {res, c} = {c, src};
        if (op == 3'h2) {c, res} = {src, c};
        if (op == 3'h6) res = {src[3:0], src[7:4]};
        if (op >= 3'h3 && op <= 3'h5) {c, res, dc, z} = {~s9[8], s9[7:0], ~s5[4], s9[7:0] == 8'h0};
        if (op == 3'h3 || !d) acc = res;
        else fileM[idx] = res;
        wbRead(OFS_ACC, {24'h0, acc}, "acc");
        wbRead(OFS_RESULT, {24'h0, res}, "result");
        wbRead(OFS_FILE_BASE + {idx, 2'h0}, {24'h0, fileM[idx]}, "file");
        wbRead(OFS_STATUS, {27'h0, to, pwrdn, z, dc, c}, "status");
    endtask : runOp

    task automatic results();
        $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] r;
        logic [3:0] idx;
        foreach (fileM[k]) fileM[k] = 8'h00;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        wbRead(OFS_STATUS, 32'h18, "status reset");
        wbRead(OFS_CMD, 32'h8, "cmd reset");
        for (int i = 0; i < 60; i++) begin
            r = nextRand();
            idx = r[11:8];
            acc = r[7:0];
            fileM[idx] = (i % 5 == 0) ? acc : r[23:16];
            {z, dc, c} = r[14:12];
            wbXfer(1'b1, OFS_ACC, 4'hf, {24'h0, acc});
            wbXfer(1'b1, OFS_FILE_BASE + {idx, 2'h0}, 4'hf, {24'h0, fileM[idx]});
            wbXfer(1'b1, OFS_STATUS, 4'hf, {27'h0, to, pwrdn, z, dc, c});
            runOp(3'(i % 6 + 1), r[15], idx, (i % 7 == 0) ? acc : r[31:24]);
        end
        // refused writes leave state alone
        wbXfer(1'b1, OFS_ACC, 4'he, 32'h5a);
        wbXfer(1'b1, 8'h84, 4'hf, 32'h5a);
        wbXfer(1'b1, OFS_CMD, 4'h1, 32'h6);
        // no-operation command: recorded, but result, accumulator and flags hold
        wbXfer(1'b1, OFS_CMD, 4'hf, 32'h0000_0008);
        wbRead(OFS_CMD, 32'h8, "cmd none");
        wbRead(OFS_RESULT, {24'h0, res}, "result after none");
        wbRead(OFS_STATUS, {27'h0, to, pwrdn, z, dc, c}, "status after none");
        wbRead(OFS_ACC, {24'h0, acc}, "acc after refused");
        wbRead(8'h20, 32'h0, "unmapped");
        // sleep after timeout cleared by software
        to = 1'b0;
        wbXfer(1'b1, OFS_STATUS, 4'hf, {27'h0, to, pwrdn, z, dc, c});
        repeat (2) @(posedge core_clk);
        cmpVal("pins", {30'h0, 1'b0, 1'b1}, {30'h0, timeoutStatus, powerdownStatus});
        repeat (40) @(posedge core_clk);
        wbXfer(1'b1, OFS_CMD, 4'hf, {29'h0, OP_SLEEP});
        {to, pwrdn} = 2'b10;
        wbRead(OFS_WDOG, 32'h0, "watchdog");
        wbRead(OFS_STATUS, {27'h0, to, pwrdn, z, dc, c}, "status sleep");
        cmpVal("pins sleep", {30'h0, 1'b1, 1'b0}, {30'h0, timeoutStatus, powerdownStatus});
        // cleared 3-bit prescaler steps the counter at the eighth edge after sleep
        wbRead(OFS_WDOG, 32'h0, "watchdog held");
        wbRead(OFS_WDOG, 32'h1, "watchdog step");
        repeat (2) @(posedge core_clk);
        results();
    end
endmodule : rotate_subtract_swap_datapath_bench
